// ==== hw/wlm_pkg.sv ====
//
// Contract
// - a burst starts when the write port select is low at a positive clock phase, and its four beats are taken on the positive and negative phases of the next two input clock cycles.
// - a start request at the positive phase right after an accepted start is disregarded, so controllers must not issue back-to-back starts.
// - the four beats go to the latched address and the three following addresses in beat order.
// - in the 8- and 18-bit organisations both lane selects low stores the whole beat.
// - lane 0 low with lane 1 high stores only the lower lane and keeps the upper lane.
// - lane 0 high with lane 1 low stores only the upper lane and keeps the lower lane.
// - in the 8- and 18-bit organisations both lane selects high writes nothing for that beat.
// - in the 9-bit organisation the single lane select low stores all nine bits of the beat.
// - in the 9- and 36-bit organisations every lane select high stores nothing for that beat.
// - in the 36-bit organisation all four lane selects low store all 36 bits.
// - in the 36-bit organisation lane select 0 alone stores bits 8..0 and keeps bits 35..9.
// - in the 36-bit organisation lane selects 1, 2 and 3 alone store bits 17..9, 26..18 and 35..27.
// - lane selects are sampled afresh at every beat and may change between beats of one burst.
package wlm_pkg;

  // ----------------------------------------
  // organisation and sizes
  // ----------------------------------------
  localparam int unsigned WLM_DATA_W = 36;
  localparam int unsigned WLM_LANES = 4;
  localparam int unsigned WLM_ADDR_W = 6;
  localparam int unsigned WLM_BUF_DEPTH = 2;
  localparam int unsigned WLM_BURST_LEN = 4;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [31:0] WLM_OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] WLM_OFS_STATUS = 32'h0000_0004;
  localparam logic [31:0] WLM_OFS_MEM_ADDR = 32'h0000_0008;
  localparam logic [31:0] WLM_OFS_MEM_LO = 32'h0000_000c;
  localparam logic [31:0] WLM_OFS_MEM_HI = 32'h0000_0010;

  localparam int unsigned WLM_CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] WLM_CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] WLM_CTRL_MASK = 32'h0000_0001;

  localparam int unsigned WLM_STAT_BURST_W = 16;
  localparam int unsigned WLM_STAT_IGN_W = 8;
  localparam int unsigned WLM_STAT_DROP_W = 8;

  // ----------------------------------------
  // phase and states
  // ----------------------------------------
  localparam logic WLM_PHASE_POS = 1'b0;

  typedef enum logic [5:0] {
    WLM_ST_IDLE = 6'h01,
    WLM_ST_WAIT = 6'h02,
    WLM_ST_B0 = 6'h04,
    WLM_ST_B1 = 6'h08,
    WLM_ST_B2 = 6'h10,
    WLM_ST_B3 = 6'h20
  } wlm_state_e;

endpackage

// ==== hw/wlm_stream_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface wlm_stream_if #(
  parameter int unsigned WIDTH = 8
) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ==== hw/wlm_beat_buffer.sv ====
`timescale 1ns/1ps
`default_nettype none

module wlm_beat_buffer #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = wlm_pkg::WLM_BUF_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // fill and drain sides
  wlm_stream_if.snk fillSide,
  wlm_stream_if.src drainSide
);
  import wlm_pkg::*;

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wrPtr_reg, wrPtr_next;
  logic [PW-1:0] rdPtr_reg, rdPtr_next;
  logic [CW-1:0] count_reg, count_next;
  logic doPush;
  logic doPop;

  function automatic logic [PW-1:0] ptrInc(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return p + 1'b1;
  endfunction

  assign fillSide.ready = (count_reg != CW'(DEPTH));
  assign drainSide.valid = (count_reg != '0);
  assign drainSide.data = store[rdPtr_reg];
  assign doPush = fillSide.valid && fillSide.ready;
  assign doPop = drainSide.valid && drainSide.ready;

  always_comb begin
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    if (doPush) begin
      wrPtr_next = ptrInc(wrPtr_reg);
    end
    if (doPop) begin
      rdPtr_next = ptrInc(rdPtr_reg);
    end
    if (doPush && !doPop) begin
      count_next = count_reg + 1'b1;
    end else if (doPop && !doPush) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end

  // storage needs no reset: empty entries are never read out
  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      store[wrPtr_reg] <= fillSide.data;
    end
  end

endmodule

`default_nettype wire

// ==== hw/wlm_write_port.sv ====
`timescale 1ns/1ps
`default_nettype none

module wlm_write_port #(
  parameter int unsigned DATA_W = wlm_pkg::WLM_DATA_W,
  parameter int unsigned LANES = wlm_pkg::WLM_LANES,
  parameter int unsigned ADDR_W = wlm_pkg::WLM_ADDR_W,
  parameter int unsigned BUF_DEPTH = wlm_pkg::WLM_BUF_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // write port pins
  input wire logic writePortSelectN,
  input wire logic [ADDR_W-1:0] writeAddr,
  input wire logic [DATA_W-1:0] writeData,
  input wire logic [LANES-1:0] laneWriteSelectN,
  // phase and flow status
  output logic posPhase,
  output logic beatReady,
  // apb slave
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import wlm_pkg::*;

  localparam int unsigned LANE_W = DATA_W / LANES;
  localparam int unsigned ENTRY_W = ADDR_W + 2 * DATA_W;
  localparam int unsigned MEM_DEPTH = 1 << ADDR_W;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  // no reset on the array: a word never written reads back unknown
  logic [DATA_W-1:0] mem [MEM_DEPTH];

  wlm_state_e state_reg, state_next;
  logic phase_reg, phase_next;
  logic [ADDR_W-1:0] base_reg, base_next;
  logic [ADDR_W-1:0] pendAddr_reg, pendAddr_next;
  logic pendValid_reg, pendValid_next;
  logic [WLM_STAT_BURST_W-1:0] burstCnt_reg, burstCnt_next;
  logic [WLM_STAT_IGN_W-1:0] ignCnt_reg, ignCnt_next;
  logic [WLM_STAT_DROP_W-1:0] dropCnt_reg, dropCnt_next;

  logic [31:0] ctrl_reg, ctrl_next;
  logic [ADDR_W-1:0] memAddr_reg, memAddr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic slverr_reg, slverr_next;

  logic startReq;
  logic beatActive;
  logic [1:0] beatIdx;
  logic [ADDR_W-1:0] beatAddr;
  logic [DATA_W-1:0] beatMask;
  logic winAccess;
  logic apbSetup;
  logic apbWrite;
  logic memWrEn;
  logic [ADDR_W-1:0] drainAddr;
  logic [DATA_W-1:0] drainMask;
  logic [DATA_W-1:0] drainData;
  logic [DATA_W-1:0] mergedWord;
  logic [63:0] peekWord;

  wlm_stream_if #(.WIDTH(ENTRY_W)) fillIf ();
  wlm_stream_if #(.WIDTH(ENTRY_W)) drainIf ();

  // ----------------------------------------
  // lane decode
  // ----------------------------------------
  // a lane select low enables its lane; the lane width falls out of the
  // organisation, so nibble lanes and 9-bit lanes share one decoder
  // x8 and x18 have two lanes, x9 one lane, x36 four lanes
  function automatic logic [DATA_W-1:0] laneMask(input logic [LANES-1:0] selN);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W; i++) begin
      m[i] = ~selN[i / LANE_W];
    end
    return m;
  endfunction

  // ----------------------------------------
  // burst sequencing
  // ----------------------------------------
  // starts count only on positive phases; clearing the enable refuses new
  // starts but lets a burst already in flight finish
  assign startReq = (phase_reg == WLM_PHASE_POS) && !writePortSelectN
    && ctrl_reg[WLM_CTRL_ENABLE_BIT];

  always_comb begin
    beatActive = 1'b1;
    beatIdx = 2'd0;
    case (state_reg)
      WLM_ST_B0: beatIdx = 2'd0;
      WLM_ST_B1: beatIdx = 2'd1;
      WLM_ST_B2: beatIdx = 2'd2;
      WLM_ST_B3: beatIdx = 2'd3;
      default: beatActive = 1'b0;
    endcase
  end

  // burst addresses wrap at the end of the array
  assign beatAddr = base_reg + ADDR_W'(beatIdx);
  assign beatMask = laneMask(laneWriteSelectN);

  // an all-high beat is not pushed at all, so the word stays untouched
  assign fillIf.valid = beatActive && (|beatMask);
  // each entry carries its own address and mask, so draining needs no burst state
  assign fillIf.data = {beatAddr, beatMask, writeData};

  // the phase flop stands for the input clock pair: it toggles every cycle,
  // starting from a positive phase after reset
  always_comb begin
    state_next = state_reg;
    phase_next = ~phase_reg;
    base_next = base_reg;
    pendAddr_next = pendAddr_reg;
    pendValid_next = pendValid_reg;
    burstCnt_next = burstCnt_reg;
    ignCnt_next = ignCnt_reg;
    dropCnt_next = dropCnt_reg;
    case (state_reg)
      WLM_ST_IDLE: begin
        if (startReq) begin
          // the address waits one phase before the beats take it over
          pendAddr_next = writeAddr;
          burstCnt_next = burstCnt_reg + 1'b1;
          state_next = WLM_ST_WAIT;
        end
      end
      WLM_ST_WAIT: begin
        base_next = pendAddr_reg;
        state_next = WLM_ST_B0;
      end
      WLM_ST_B0: begin
        // a start at the positive phase right after an accepted one is only counted
        if (startReq) begin
          ignCnt_next = ignCnt_reg + 1'b1;
        end
        state_next = WLM_ST_B1;
      end
      WLM_ST_B1: begin
        state_next = WLM_ST_B2;
      end
      WLM_ST_B2: begin
        // the next burst's waiting phase overlaps this burst's last beat
        if (startReq) begin
          pendAddr_next = writeAddr;
          pendValid_next = 1'b1;
          burstCnt_next = burstCnt_reg + 1'b1;
        end
        state_next = WLM_ST_B3;
      end
      WLM_ST_B3: begin
        // a start taken in the third beat follows on seamlessly, with no
        // idle phase between the two bursts
        if (pendValid_reg) begin
          base_next = pendAddr_reg;
          pendValid_next = 1'b0;
          state_next = WLM_ST_B0;
        end else begin
          state_next = WLM_ST_IDLE;
        end
      end
      default: begin
        state_next = WLM_ST_IDLE;
      end
    endcase
    // a beat that finds the buffer full is lost; only a long peek can
    // hold the drain that long, so the count shows software interference
    if (fillIf.valid && !fillIf.ready) begin
      dropCnt_next = dropCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= WLM_ST_IDLE;
      phase_reg <= WLM_PHASE_POS;
      base_reg <= '0;
      pendAddr_reg <= '0;
      pendValid_reg <= 1'b0;
      burstCnt_reg <= '0;
      ignCnt_reg <= '0;
      dropCnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      base_reg <= base_next;
      pendAddr_reg <= pendAddr_next;
      pendValid_reg <= pendValid_next;
      burstCnt_reg <= burstCnt_next;
      ignCnt_reg <= ignCnt_next;
      dropCnt_reg <= dropCnt_next;
    end
  end

  // ----------------------------------------
  // beat buffer and array write
  // ----------------------------------------
  // two entries absorb the beats of a short peek; longer peeks lose beats
  wlm_beat_buffer #(
    .WIDTH(ENTRY_W),
    .DEPTH(BUF_DEPTH)
  ) u_buffer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .fillSide(fillIf.snk),
    .drainSide(drainIf.src)
  );

  // array writes pause while software peeks, so a peek sees one stable word;
  // the buffer absorbs up to two beats that arrive meanwhile
  assign winAccess = psel
    && ((paddr == WLM_OFS_MEM_LO) || (paddr == WLM_OFS_MEM_HI));
  assign drainIf.ready = !winAccess;
  assign memWrEn = drainIf.valid && drainIf.ready;

  assign drainAddr = drainIf.data[ENTRY_W-1 -: ADDR_W];
  assign drainMask = drainIf.data[2*DATA_W-1 -: DATA_W];
  assign drainData = drainIf.data[DATA_W-1:0];

  // disabled lanes keep their stored bits
  assign mergedWord = (mem[drainAddr] & ~drainMask) | (drainData & drainMask);

  always_ff @(posedge clk_sys) begin
    if (memWrEn) begin
      mem[drainAddr] <= mergedWord;
    end
  end

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite;
  assign peekWord = 64'(mem[memAddr_reg]);

  // read data is loaded in the setup cycle and stands through the access
  // phase, which lets pready stay high: every access phase takes one cycle
  always_comb begin
    ctrl_next = ctrl_reg;
    memAddr_next = memAddr_reg;
    prdata_next = prdata_reg;
    slverr_next = slverr_reg;
    if (apbSetup) begin
      slverr_next = 1'b0;
      prdata_next = '0;
      case (paddr)
        WLM_OFS_CTRL: prdata_next = ctrl_reg;
        WLM_OFS_STATUS: prdata_next = {dropCnt_reg, ignCnt_reg, burstCnt_reg};
        WLM_OFS_MEM_ADDR: prdata_next = 32'(memAddr_reg);
        WLM_OFS_MEM_LO: prdata_next = peekWord[31:0];
        WLM_OFS_MEM_HI: prdata_next = peekWord[63:32];
        default: slverr_next = 1'b1;
      endcase
    end
    if (apbWrite) begin
      case (paddr)
        WLM_OFS_CTRL: ctrl_next = pwdata & WLM_CTRL_MASK;
        WLM_OFS_MEM_ADDR: memAddr_next = pwdata[ADDR_W-1:0];
        // read-only and unmapped offsets take no write
        default: ctrl_next = ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= WLM_CTRL_RESET;
      memAddr_reg <= '0;
      prdata_reg <= '0;
      slverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      memAddr_reg <= memAddr_next;
      prdata_reg <= prdata_next;
      slverr_reg <= slverr_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = prdata_reg;
  // the error is decoded in setup and shown only in the access phase
  assign pslverr = slverr_reg && psel && penable;
  assign pready = 1'b1;
  assign posPhase = (phase_reg == WLM_PHASE_POS);
  assign beatReady = fillIf.ready;

endmodule

`default_nettype wire

// ==== test/wlm_write_port_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module wlm_write_port_checker #(
  parameter int unsigned DATA_W = 36,
  parameter int unsigned LANES = 4,
  parameter int unsigned ADDR_W = 6,
  parameter int unsigned BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // write port pins
  input wire logic writePortSelectN,
  input wire logic [ADDR_W-1:0] writeAddr,
  input wire logic [DATA_W-1:0] writeData,
  input wire logic [LANES-1:0] laneWriteSelectN,
  // phase and flow
  input wire logic posPhase,
  input wire logic beatReady,
  // apb
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import wlm_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // two settled cycles keep the reset value of the phase flop out of the comparison
  AST_PHASE_ALT: assert property ($past(rstn, 2) && $past(rstn) |-> posPhase != $past(posPhase))
    else $error("phase did not alternate");
  // once draining resumes, one beat a cycle never fills the buffer
  AST_DRAIN_READY: assert property ((!psel) [*2] |-> beatReady)
    else $error("buffer full without a stall");
  AST_ZERO_WAIT: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_ERR_ONLY_ACCESS: assert property (pslverr |-> psel && penable && prdata == 32'h0000_0000)
    else $error("error outside access or with data");
  AST_ERR_UNMAPPED: assert property (psel && !penable ##1 penable && paddr == 32'h0000_0014 |-> pslverr)
    else $error("unmapped address without error");
  AST_NO_ERR_STATUS: assert property (psel && penable && paddr == WLM_OFS_STATUS |-> !pslverr)
    else $error("error on a mapped register");
  AST_CTRL_BITS: assert property (psel && penable && !pwrite && paddr == WLM_OFS_CTRL
                                  |-> (prdata & ~WLM_CTRL_MASK) == 32'h0000_0000)
    else $error("unused control bits read back set");
  AST_PRDATA_HOLD: assert property (!($past(psel) && !$past(penable)) |-> $stable(prdata))
    else $error("read data moved outside setup");
  COV_FULL: cover property (!beatReady);
endmodule
bind wlm_write_port wlm_write_port_checker #(
  .DATA_W(DATA_W), .LANES(LANES), .ADDR_W(ADDR_W), .BUF_DEPTH(BUF_DEPTH)
) chk_u (
  .clk_sys(clk_sys), .rstn(rstn), .writePortSelectN(writePortSelectN),
  .writeAddr(writeAddr), .writeData(writeData), .laneWriteSelectN(laneWriteSelectN),
  .posPhase(posPhase), .beatReady(beatReady), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr)
);
`default_nettype wire

// ==== test/wlm_ctl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module wlm_ctl_model (
  // clock and phase
  input wire logic clk_sys,
  input wire logic posPhase,
  // write port pins
  output logic writePortSelectN,
  output logic [wlm_pkg::WLM_ADDR_W-1:0] writeAddr,
  output logic [35:0] writeData,
  output logic [3:0] laneWriteSelectN
);
  import wlm_pkg::*;
  initial begin
    writePortSelectN = 1'b1;
    writeAddr = '0;
    writeData = '0;
    laneWriteSelectN = '1;
  end
  // dup raises a second start at the positive phase right after the first
  task automatic burst(input logic [WLM_ADDR_W-1:0] a, input logic [3:0][35:0] d,
                       input logic [3:0][3:0] s, input bit dup);
    int i;
    // old phase low at this edge means the coming cycle is positive
    @(posedge clk_sys);
    while (posPhase !== 1'b0) @(posedge clk_sys);
    writePortSelectN <= 1'b0;
    writeAddr <= a;
    @(posedge clk_sys);
    writePortSelectN <= 1'b1;
    writeAddr <= ~a;
    for (i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      writePortSelectN <= !(dup && i == 0);
      writeData <= d[i];
      laneWriteSelectN <= s[i];
    end
    @(posedge clk_sys);
    writeData <= ~d[3];
    laneWriteSelectN <= '1;
  endtask
endmodule
`default_nettype wire

// ==== test/wlm_write_port_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module wlm_write_port_tb_top;
  import wlm_pkg::*;
  logic clk_sys, rstn, posPhase, beatReady, writePortSelectN;
  logic [5:0] writeAddr;
  logic [35:0] writeData;
  logic [3:0] laneWriteSelectN;
  logic psel, penable, pwrite, pready, pslverr, apbErr;
  logic [31:0] paddr, pwdata, prdata, v32;
  logic [3:0][35:0] dat;
  logic [35:0] expMem [64];
  int n_errors = 0;
  int compares = 0;
  wlm_write_port dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .writePortSelectN(writePortSelectN),
    .writeAddr(writeAddr), .writeData(writeData), .laneWriteSelectN(laneWriteSelectN),
    .posPhase(posPhase), .beatReady(beatReady), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );
  wlm_ctl_model ctl_u (
    .clk_sys(clk_sys), .posPhase(posPhase), .writePortSelectN(writePortSelectN),
    .writeAddr(writeAddr), .writeData(writeData), .laneWriteSelectN(laneWriteSelectN)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // psel stays up unless last, so reads can follow back to back
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input bit last, output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    apbErr = pslverr;
    penable <= 1'b0;
    if (last) begin
      psel <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task automatic peek(input logic [5:0] a, output logic [35:0] v);
    logic [31:0] lo, hi;
    apb(1'b1, WLM_OFS_MEM_ADDR, 32'(a), 1'b1, lo);
    apb(1'b0, WLM_OFS_MEM_LO, 32'h0000_0000, 1'b1, lo);
    apb(1'b0, WLM_OFS_MEM_HI, 32'h0000_0000, 1'b1, hi);
    v = {hi[3:0], lo};
  endtask
  task automatic makeData(input logic [35:0] base);
    for (int i = 0; i < 4; i++) dat[i] = base ^ (36'h1_1111_1111 << i);
  endtask
  task automatic merge(input logic [5:0] a, input logic [3:0][3:0] s);
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 4; k++) begin
        if (!s[i][k]) expMem[6'(a + i)][k*9 +: 9] = dat[i][k*9 +: 9];
      end
    end
  endtask
  task automatic checkMem(input logic [5:0] a);
    logic [35:0] v;
    for (int i = 0; i < 4; i++) begin
      peek(6'(a + i), v);
      check(v, expMem[6'(a + i)]);
    end
  endtask
  task automatic burstChk(input logic [5:0] a, input logic [3:0][3:0] s, input bit dup);
    ctl_u.burst(a, dat, s, dup);
    repeat (2) @(posedge clk_sys);
    merge(a, s);
    checkMem(a);
  endtask
  // ----------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (4000) @(posedge clk_sys);
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_of_test();
  end
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, WLM_OFS_CTRL, 32'h0000_0000, 1'b1, v32);
    check(36'(v32), 36'(WLM_CTRL_RESET));
    apb(1'b0, WLM_OFS_STATUS, 32'h0000_0000, 1'b1, v32);
    check(36'(v32), 36'h0_0000_0000);
    apb(1'b0, 32'h0000_0014, 32'h0000_0000, 1'b1, v32);
    check(36'(apbErr), 36'h1);
    $display("test registers done");
    makeData(36'h0_1234_5678);
    burstChk(6'h3e, 16'h0000, 1'b0);
    makeData(36'hf_edcb_a987);
    burstChk(6'h3e, 16'h7bde, 1'b0);
    makeData(36'h5_a5a5_a5a5);
    burstChk(6'h3e, 16'hffff, 1'b0);
    $display("test lanes done");
    // unused control bits are masked, and a disabled block refuses starts
    apb(1'b1, WLM_OFS_CTRL, 32'hffff_fffe, 1'b1, v32);
    apb(1'b0, WLM_OFS_CTRL, 32'h0000_0000, 1'b1, v32);
    check(36'(v32), 36'h0_0000_0000);
    ctl_u.burst(6'h3e, dat, 16'h0000, 1'b0);
    repeat (2) @(posedge clk_sys);
    checkMem(6'h3e);
    apb(1'b1, WLM_OFS_CTRL, 32'h0000_0001, 1'b1, v32);
    $display("test disable done");
    makeData(36'h3_0f0f_0f0f);
    burstChk(6'h10, 16'h0000, 1'b1);
    apb(1'b0, WLM_OFS_STATUS, 32'h0000_0000, 1'b1, v32);
    check(36'(v32), 36'h0_0001_0004);
    $display("test repeat start done");
    makeData(36'h9_8765_4321);
    burstChk(6'h20, 16'h0000, 1'b0);
    makeData(36'h6_cafe_0001);
    // back to back peeks hold the drain, so the last two beats are dropped
    fork
      for (int k = 0; k < 12; k++) apb(1'b0, WLM_OFS_MEM_LO, 32'h0000_0000, k == 11, v32);
      ctl_u.burst(6'h20, dat, 16'h0000, 1'b0);
    join
    repeat (2) @(posedge clk_sys);
    check(36'(beatReady), 36'h1);
    merge(6'h20, 16'hff00);
    checkMem(6'h20);
    apb(1'b0, WLM_OFS_STATUS, 32'h0000_0000, 1'b1, v32);
    check(36'(v32), 36'h0_0201_0006);
    $display("test stall done");
    end_of_test();
  end
endmodule
`default_nettype wire
